// *** pbmc_top.sv ***
// Link mode control register bank behind the serial management pins
`timescale 1ns/1ns
`include "pbmc_regs.svh"
// Contract
// - Every register is a 16-bit word picked by a five-bit address.
// - Addresses 08h-0Fh, 1Ah and 1Dh-1Fh are reserved.
// - Listed addresses are read-only; the others are read/write.
// - Writing bit 15 resets all registers; reads one until recalibration ends.
// - A mode change sets bit 15 until the forced recalibration ends.
// - Bit 14 loops transmit data to receive at either speed; resets zero.
// - Loopback pin rising sets bit 14, falling clears it.
// - Without negotiation bit 13 picks 100 or 10 Mb/s.
// - Bit 12 enables negotiation, which then overrides bits 13 and 8.
// - Bit 11 holds the low-power state; resets zero.
// - Legacy mode bit in 1Ch disables power-down and blocks its writes.
// - Bit 10 isolates the MII; reset from address and isolate pin.
// - Bit 9 restarts negotiation and self-clears once it begins.
// - Without negotiation bit 8 picks full or half duplex.
// - Bit 7 echoes transmit enable on collision within the bit-time limits.
module pbmc_top
    import pbmc_pkg::*;
#(
    parameter int RECAL_CYC = `PBMC_RECAL_CYC,
    parameter pbmc_word_t ID_UPPER = 16'h0a5a, // Arbitrary identity value
    parameter pbmc_word_t ID_LOWER = 16'h5a01, // Arbitrary identity value
    parameter logic ANEN_RST = 1'b1,
    parameter logic SPEED_RST = 1'b1,
    parameter logic DUP_RST = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [4:0] station_address_pins,
    input wire logic isolate_default_pin,
    input wire logic loopback_pin,
    input wire logic tx_en,
    input wire logic col_in,
    input wire logic autoneg_started,
    input wire logic autoneg_complete,
    input wire logic link_up,
    input wire logic neg_speed_100,
    input wire logic neg_full_duplex,
    input wire logic [6:0][15:0] ro_status,
    output logic loopback_en,
    output logic speed_100,
    output logic full_duplex,
    output logic autoneg_en,
    output logic autoneg_restart,
    output logic power_down,
    output logic mii_isolate,
    output logic recal_active,
    output logic col_out,
    output logic col_oe
);
    pbmc_tmr_if tif ();
    logic [8:0] pin_s;
    logic mdc_s, mdio_s, lpk_s, isolate_default_pin_s, mdc_q_r, lpk_q_r, mdc_rise;
    logic [4:0] ad_s;
    pbmc_mstate_t ms_r;
    logic [5:0] cnt_r, pre_r;
    logic [11:0] hdr_r;
    logic [12:0] hdr_full;
    pbmc_word_t sh_r, rd_val, wdata_r;
    logic [4:0] rd_addr, wr_addr_r;
    logic is_rd_r, wr_stb_r, hdr_ok, rsvd_hit;
    logic [`PBMC_RW_NUM-1:0][15:0] mem_r;
    logic [3:0] rd_sel, wr_sel;
    logic srst_r, loop_r, speed_r, anen_r, pdn_r, iso_r, anrs_r, dup_r, colt_r;
    logic [2:0] strap_r;
    logic strap_ld, iso_strap, legacy, presup, wr_ctrl;
    logic [2:0] mode_now, mode_q_r;

    pbmc_sync #(.WIDTH(9)) u_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .d({station_address_pins, isolate_default_pin, loopback_pin, mdio_in, mdc}),
        .q(pin_s)
    );
    pbmc_timer #(.COUNT(RECAL_CYC)) u_recal (
        .clk(ref_clk),
        .rst(sys_rst),
        .t(tif.timer)
    );
    assign {ad_s, isolate_default_pin_s, lpk_s, mdio_s, mdc_s} = pin_s;
    assign mdc_rise = mdc_s & ~mdc_q_r;
    assign legacy = mem_r[`PBMC_I_TBC][`PBMC_LEGACY_BIT];
    assign presup = mem_r[`PBMC_I_PCS][`PBMC_PRESUP_BIT];
    assign strap_ld = (strap_r == 3'h1);
    assign iso_strap = (ad_s == `PBMC_AD_BCAST) | isolate_default_pin_s;
    assign wr_ctrl = wr_stb_r && (wr_addr_r == `PBMC_A_CTRL);

    function automatic logic [3:0] rw_index(input logic [4:0] a);
        case (a)
            `PBMC_A_ADV: rw_index = `PBMC_I_ADV;
            `PBMC_A_NXP: rw_index = `PBMC_I_NXP;
            `PBMC_A_MASK: rw_index = `PBMC_I_MASK;
            `PBMC_A_SCR: rw_index = `PBMC_I_SCR;
            `PBMC_A_DSCR: rw_index = `PBMC_I_DSCR;
            `PBMC_A_PCS: rw_index = `PBMC_I_PCS;
            `PBMC_A_LBM: rw_index = `PBMC_I_LBM;
            `PBMC_A_SELF: rw_index = `PBMC_I_SELF;
            `PBMC_A_TBC: rw_index = `PBMC_I_TBC;
            default: rw_index = `PBMC_I_NONE;
        endcase
    endfunction : rw_index

    assign hdr_full = {hdr_r, mdio_s};
    assign rd_addr = hdr_full[4:0];
    assign rd_sel = rw_index(rd_addr);
    assign wr_sel = rw_index(wr_addr_r);
    assign hdr_ok = hdr_full[12]
        && (hdr_full[11:10] == `PBMC_OP_RD || hdr_full[11:10] == `PBMC_OP_WR)
        && (hdr_full[9:5] == `PBMC_AD_BCAST || hdr_full[9:5] == mem_r[`PBMC_I_SELF][4:0]);

    always_comb begin
        rd_val = '0;
        rsvd_hit = 1'b0;
        if (rd_sel != `PBMC_I_NONE) begin
            rd_val = mem_r[rd_sel];
        end else begin
            case (rd_addr)
                `PBMC_A_CTRL: rd_val = {srst_r | tif.busy, loop_r, speed_r, anen_r, pdn_r,
                    iso_r, anrs_r, dup_r, colt_r, `PBMC_CTRL_RSVD};
                `PBMC_A_STAT: rd_val = {1'b0, mem_r[`PBMC_I_ADV][`PBMC_ADV_HI:`PBMC_ADV_LO],
                    4'h0, presup, autoneg_complete, 1'b0, 1'b1, link_up, 1'b0, 1'b1};
                `PBMC_A_ID1: rd_val = ID_UPPER;
                `PBMC_A_ID2: rd_val = ID_LOWER;
                `PBMC_A_PART: rd_val = ro_status[0];
                `PBMC_A_EXP: rd_val = ro_status[1];
                `PBMC_A_EVT: rd_val = ro_status[2];
                `PBMC_A_DISC: rd_val = ro_status[3];
                `PBMC_A_FCAR: rd_val = ro_status[4];
                `PBMC_A_RXE: rd_val = ro_status[5];
                `PBMC_A_TBS: rd_val = ro_status[6];
                default: rsvd_hit = 1'b1;
            endcase
        end
    end

    // Management frame engine; MDIO changes just after the rising MDC edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_r <= MS_IDLE;
            cnt_r <= '0;
            pre_r <= '0;
            hdr_r <= '0;
            sh_r <= '0;
            is_rd_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_addr_r <= '0;
            wdata_r <= '0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            mdc_q_r <= 1'b0;
        end else begin
            mdc_q_r <= mdc_s;
            wr_stb_r <= 1'b0;
            if (mdc_rise) begin
                unique case (ms_r)
                    MS_IDLE: begin
                        mdio_oe <= 1'b0;
                        if (mdio_s) begin
                            pre_r <= (pre_r == `PBMC_PRE_LEN) ? pre_r : pre_r + 1'b1;
                        end else begin
                            pre_r <= '0;
                            cnt_r <= '0;
                            if (pre_r == `PBMC_PRE_LEN || presup) begin
                                ms_r <= MS_HDR;
                            end
                        end
                    end
                    MS_HDR: begin
                        hdr_r <= hdr_full[11:0];
                        cnt_r <= cnt_r + 1'b1;
                        if (cnt_r == `PBMC_HDR_LAST) begin
                            cnt_r <= '0;
                            ms_r <= hdr_ok ? MS_TA : MS_IDLE;
                            is_rd_r <= (hdr_full[11:10] == `PBMC_OP_RD);
                            wr_addr_r <= rd_addr;
                            sh_r <= rd_val;
                        end
                    end
                    MS_TA: begin
                        cnt_r <= cnt_r + 1'b1;
                        if (cnt_r == '0) begin
                            mdio_oe <= is_rd_r;
                            mdio_out <= 1'b0;
                        end else begin
                            cnt_r <= '0;
                            ms_r <= MS_DATA;
                            if (is_rd_r) begin
                                mdio_out <= sh_r[15];
                                sh_r <= {sh_r[14:0], 1'b0};
                            end
                        end
                    end
                    MS_DATA: begin
                        cnt_r <= cnt_r + 1'b1;
                        if (is_rd_r) begin
                            mdio_out <= sh_r[15];
                            sh_r <= {sh_r[14:0], 1'b0};
                        end else begin
                            sh_r <= {sh_r[14:0], mdio_s};
                        end
                        if (cnt_r == `PBMC_DATA_LAST) begin
                            ms_r <= MS_IDLE;
                            mdio_oe <= 1'b0;
                            wr_stb_r <= ~is_rd_r;
                            wdata_r <= {sh_r[14:0], mdio_s};
                        end
                    end
                endcase
            end
        end
    end

    // Straps settle through the synchroniser before they are taken
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_r <= `PBMC_STRAP_WAIT;
        end else if (srst_r) begin
            strap_r <= `PBMC_STRAP_WAIT;
        end else if (strap_r != 3'h0) begin
            strap_r <= strap_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `PBMC_RW_NUM; i++) begin
                mem_r[i] <= (i == 0) ? `PBMC_ADV_RST : `PBMC_RW_RST;
            end
        end else if (srst_r) begin
            for (int i = 0; i < `PBMC_RW_NUM; i++) begin
                mem_r[i] <= (i == 0) ? `PBMC_ADV_RST : `PBMC_RW_RST;
            end
        end else begin
            if (wr_stb_r && wr_sel != `PBMC_I_NONE) begin
                mem_r[wr_sel] <= wdata_r;
            end
            if (strap_ld) begin
                mem_r[`PBMC_I_SELF][4:0] <= ad_s;
            end
        end
    end

    // Control word; soft reset restores the power-on defaults except isolate, which it loads from the straps at once
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            srst_r <= 1'b0;
            loop_r <= 1'b0;
            speed_r <= SPEED_RST;
            anen_r <= ANEN_RST;
            pdn_r <= 1'b0;
            iso_r <= 1'b1;
            anrs_r <= 1'b0;
            dup_r <= DUP_RST;
            colt_r <= 1'b0;
            lpk_q_r <= 1'b0;
        end else begin
            lpk_q_r <= lpk_s;
            if (srst_r) begin
                srst_r <= 1'b0;
                loop_r <= 1'b0;
                speed_r <= SPEED_RST;
                anen_r <= ANEN_RST;
                pdn_r <= 1'b0;
                iso_r <= iso_strap;
                anrs_r <= 1'b0;
                dup_r <= DUP_RST;
                colt_r <= 1'b0;
            end else begin
                if (wr_ctrl) begin
                    srst_r <= wdata_r[`PBMC_B_SRST];
                    loop_r <= wdata_r[`PBMC_B_LOOP];
                    speed_r <= wdata_r[`PBMC_B_SPEED];
                    anen_r <= wdata_r[`PBMC_B_ANEN];
                    iso_r <= wdata_r[`PBMC_B_ISO];
                    dup_r <= wdata_r[`PBMC_B_DUP];
                    colt_r <= wdata_r[`PBMC_B_COLT];
                end
                if (wr_ctrl && !legacy) begin
                    pdn_r <= wdata_r[`PBMC_B_PDN];
                end
                if (lpk_s && !lpk_q_r) begin
                    loop_r <= 1'b1;
                end else if (!lpk_s && lpk_q_r) begin
                    loop_r <= 1'b0;
                end
                // set wins over the start clear
                if (wr_ctrl && wdata_r[`PBMC_B_ANRS]) begin
                    anrs_r <= 1'b1;
                end else if (autoneg_started) begin
                    anrs_r <= 1'b0;
                end
                if (strap_ld) begin
                    iso_r <= iso_strap;
                end
            end
        end
    end

    assign mode_now = {anen_r, anen_r ? neg_speed_100 : speed_r,
        anen_r ? neg_full_duplex : dup_r};
    // mode change or soft reset recalibrates
    assign tif.start = srst_r | (mode_now != mode_q_r);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q_r <= {ANEN_RST, SPEED_RST, DUP_RST};
            loopback_en <= 1'b0;
            speed_100 <= 1'b0;
            full_duplex <= 1'b0;
            autoneg_en <= 1'b0;
            autoneg_restart <= 1'b0;
            power_down <= 1'b0;
            mii_isolate <= 1'b1;
            recal_active <= 1'b0;
            col_out <= 1'b0;
            col_oe <= 1'b0;
        end else begin
            mode_q_r <= mode_now;
            loopback_en <= loop_r;
            speed_100 <= mode_now[1];
            full_duplex <= mode_now[0];
            autoneg_en <= anen_r;
            autoneg_restart <= anrs_r;
            power_down <= pdn_r & ~legacy;
            mii_isolate <= iso_r;
            recal_active <= srst_r | tif.busy;
            // collision test echo; isolated MII stays quiet
            col_out <= ~iso_r & (colt_r ? tx_en : col_in);
            col_oe <= ~iso_r;
        end
    end

    localparam int COL_ON = `PBMC_COL_ON_CYC;
    localparam int COL_OFF = `PBMC_COL_OFF_CYC;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_rsvd_reads_zero: assert property (
        (mdc_rise && ms_r == MS_HDR && cnt_r == `PBMC_HDR_LAST && rsvd_hit) |=> sh_r == '0)
        else $error("reserved address did not read zero");
    a_ro_write_drop: assert property (
        (wr_stb_r && wr_sel == `PBMC_I_NONE && !strap_ld) |=> $stable(mem_r))
        else $error("write to read-only word changed storage");
    a_srst_busy: assert property (
        srst_r |=> recal_active && tif.busy [*8])
        else $error("soft reset bit dropped before recalibration");
    a_mode_recal: assert property (
        (mode_now != mode_q_r && !srst_r) |=> tif.busy ##1 recal_active)
        else $error("mode change did not start recalibration");
    a_loop_pin: assert property (
        (lpk_s && !lpk_q_r && !srst_r) |=> loop_r ##1 loopback_en)
        else $error("loopback pin rise did not set loopback");
    a_speed_manual: assert property (
        (!anen_r && !srst_r) |=> speed_100 == $past(speed_r))
        else $error("manual speed not applied");
    a_pdn_legacy: assert property (
        (wr_ctrl && legacy && !srst_r) |=> $stable(pdn_r))
        else $error("power-down written in legacy mode");
    a_iso_quiet: assert property (
        iso_r |=> !col_oe && !col_out)
        else $error("isolated MII still driven");
    a_restart_clear: assert property (
        (autoneg_started && !wr_ctrl && !srst_r) |=> !anrs_r ##1 !autoneg_restart)
        else $error("restart bit did not clear");
    a_col_echo: assert property (
        (colt_r && !iso_r && $rose(tx_en)) |-> ##[1:COL_ON] col_out)
        else $error("collision test late on assert");
    a_col_release: assert property (
        (colt_r && !iso_r && $fell(tx_en)) |-> ##[1:COL_OFF] !col_out)
        else $error("collision test late on release");
    c_soft_reset: cover property (srst_r ##1 tif.busy);
    c_read_frame: cover property (ms_r == MS_DATA && is_rd_r && mdio_oe);
    c_write_frame: cover property (wr_stb_r && wr_addr_r == `PBMC_A_CTRL);
endmodule : pbmc_top

// *** pbmc_regs.svh ***
// Register map, field positions and timing figures of the link mode control bank
`ifndef PBMC_REGS_SVH
`define PBMC_REGS_SVH
`define PBMC_A_CTRL 5'h00
`define PBMC_A_STAT 5'h01
`define PBMC_A_ID1 5'h02
`define PBMC_A_ID2 5'h03
`define PBMC_A_ADV 5'h04
`define PBMC_A_PART 5'h05
`define PBMC_A_EXP 5'h06
`define PBMC_A_NXP 5'h07
`define PBMC_A_MASK 5'h10
`define PBMC_A_EVT 5'h11
`define PBMC_A_DISC 5'h12
`define PBMC_A_FCAR 5'h13
`define PBMC_A_SCR 5'h14
`define PBMC_A_RXE 5'h15
`define PBMC_A_DSCR 5'h16
`define PBMC_A_PCS 5'h17
`define PBMC_A_LBM 5'h18
`define PBMC_A_SELF 5'h19
`define PBMC_A_TBS 5'h1b
`define PBMC_A_TBC 5'h1c
`define PBMC_I_ADV 4'h0
`define PBMC_I_NXP 4'h1
`define PBMC_I_MASK 4'h2
`define PBMC_I_SCR 4'h3
`define PBMC_I_DSCR 4'h4
`define PBMC_I_PCS 4'h5
`define PBMC_I_LBM 4'h6
`define PBMC_I_SELF 4'h7
`define PBMC_I_TBC 4'h8
`define PBMC_I_NONE 4'hf
`define PBMC_RW_NUM 9
`define PBMC_B_SRST 15
`define PBMC_B_LOOP 14
`define PBMC_B_SPEED 13
`define PBMC_B_ANEN 12
`define PBMC_B_PDN 11
`define PBMC_B_ISO 10
`define PBMC_B_ANRS 9
`define PBMC_B_DUP 8
`define PBMC_B_COLT 7
`define PBMC_CTRL_RSVD 7'h00
`define PBMC_PRESUP_BIT 9
`define PBMC_LEGACY_BIT 0
`define PBMC_ADV_HI 8
`define PBMC_ADV_LO 5
`define PBMC_ADV_RST 16'h01e1
`define PBMC_RW_RST 16'h0000
`define PBMC_AD_BCAST 5'h00
`define PBMC_PRE_LEN 6'h20
`define PBMC_HDR_LAST 6'h0c
`define PBMC_DATA_LAST 6'h0f
`define PBMC_OP_RD 2'h2
`define PBMC_OP_WR 2'h1
`define PBMC_STRAP_WAIT 3'h6
`define PBMC_CLK_NS 40
`define PBMC_RECAL_NS 10000
`define PBMC_RECAL_CYC ((`PBMC_RECAL_NS + `PBMC_CLK_NS - 1) / `PBMC_CLK_NS)
`define PBMC_BIT_NS 10
`define PBMC_COL_ON_BT 10
`define PBMC_COL_OFF_BT 4
`define PBMC_COL_ON_CYC ((`PBMC_COL_ON_BT * `PBMC_BIT_NS) / `PBMC_CLK_NS)
`define PBMC_COL_OFF_CYC ((`PBMC_COL_OFF_BT * `PBMC_BIT_NS) / `PBMC_CLK_NS)
`endif

// *** pbmc_pkg.sv ***
// Types shared by the link mode control bank
package pbmc_pkg;
    typedef enum logic [3:0] {
        MS_IDLE = 4'h1,
        MS_HDR = 4'h2,
        MS_TA = 4'h4,
        MS_DATA = 4'h8
    } pbmc_mstate_t;
    typedef logic [15:0] pbmc_word_t;
endpackage : pbmc_pkg

// *** pbmc_tmr_if.sv ***
// Start and busy pair between the bank and its recalibration timer
`timescale 1ns/1ns
interface pbmc_tmr_if;
    logic start;
    logic busy;
    modport owner (output start, input busy);
    modport timer (input start, output busy);
endinterface : pbmc_tmr_if

// *** pbmc_sync.sv ***
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module pbmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Only a level seen twice counts
            q_r <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
        end
    end
    assign q = q_r;
endmodule : pbmc_sync

// *** pbmc_timer.sv ***
// Reloadable countdown that holds busy while analog recalibration runs
`timescale 1ns/1ns
module pbmc_timer #(
    parameter int COUNT = 250
) (
    input wire logic clk,
    input wire logic rst,
    pbmc_tmr_if.timer t
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (t.start) begin
            cnt_r <= W'(COUNT);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
    assign t.busy = (cnt_r != '0);
endmodule : pbmc_timer

// *** pbmc_mac_model.sv ***
// Station manager model that clocks management frames into the bank
`timescale 1ns/1ns
module pbmc_mac_model
    import pbmc_pkg::*;
(
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output logic mdc,
    output logic mdio_in
);
    logic mac_oe = 1'b0;
    logic mac_d = 1'b1;
    // Released line settles to the pull-up level
    assign mdio_in = mdio_oe ? mdio_out : (mac_oe ? mac_d : 1'b1);
    initial mdc = 1'b0;
    // Clock stands low between frames; data moves on the falling half
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input pbmc_word_t wd,
                         output pbmc_word_t rdv);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'b01, op, 5'h00, ra, 2'b10, wd};
        for (int i = 0; i < 64; i++) begin
            mac_oe = !(op == 2'b10 && i >= 46);
            mac_d = bits[63-i];
            #160;
            if (i >= 48) rdv[63-i] = mdio_in;
            mdc = 1'b1;
            #160;
            mdc = 1'b0;
        end
        mac_oe = 1'b0;
    endtask : frame
endmodule : pbmc_mac_model

// *** phy_basic_mode_control_regs_test.sv ***
// Self-checking bench for the link mode control bank
`timescale 1ns/1ns
`include "pbmc_regs.svh"
module phy_basic_mode_control_regs_test
    import pbmc_pkg::*;
;
    localparam pbmc_word_t ID_HI = 16'h3c3c; // Arbitrary identity value
    localparam pbmc_word_t ID_LO = 16'hc3c3; // Arbitrary identity value
    localparam logic [1:0] RD = `PBMC_OP_RD;
    localparam logic [1:0] WR = `PBMC_OP_WR;
    logic ref_clk, sys_rst, mdc, mdio_in, mdio_out, mdio_oe, tx_en, col_in, an_start;
    logic an_done, link_up, neg_spd, neg_dup, loopback_pin, isolate_default_pin;
    logic loop_en, spd, fdx, an_en, an_rs, pdn, iso, recal, col_out, col_oe;
    logic [4:0] station_address_pins;
    logic [6:0][15:0] ro_status;
    int n_mismatch = 0;
    int samples_checked = 0;
    pbmc_word_t rd;
    wire [15:0] outs = {8'h00, loop_en, spd, fdx, an_en, an_rs, pdn, iso, recal};

    pbmc_top #(.RECAL_CYC(600), .ID_UPPER(ID_HI), .ID_LOWER(ID_LO)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .station_address_pins(station_address_pins),
        .isolate_default_pin(isolate_default_pin), .loopback_pin(loopback_pin),
        .tx_en(tx_en), .col_in(col_in), .autoneg_started(an_start),
        .autoneg_complete(an_done), .link_up(link_up), .neg_speed_100(neg_spd),
        .neg_full_duplex(neg_dup), .ro_status(ro_status), .loopback_en(loop_en),
        .speed_100(spd), .full_duplex(fdx), .autoneg_en(an_en), .autoneg_restart(an_rs),
        .power_down(pdn), .mii_isolate(iso), .recal_active(recal), .col_out(col_out),
        .col_oe(col_oe));
    pbmc_mac_model i_mac (.mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic chk(input pbmc_word_t got, input pbmc_word_t exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic [1:0] op, input logic [4:0] ra, input pbmc_word_t wd);
        @(posedge ref_clk);
        #3;
        i_mac.frame(op, ra, wd, rd);
        repeat (8) @(posedge ref_clk);
        #3;
    endtask : acc

    // Bounded wait for the forced recalibration to end
    task automatic waitr;
        for (int i = 0; i < 2000 && recal !== 1'b0; i++) @(posedge ref_clk);
        if (recal !== 1'b0) n_mismatch++;
        #3;
    endtask : waitr

    function automatic pbmc_word_t exp_reg(input logic [4:0] a, input logic w);
        case (a)
            5'h01: exp_reg = {5'h0f, 4'h0, w, an_done, 2'b01, link_up, 2'b01};
            5'h02: exp_reg = ID_HI;
            5'h03: exp_reg = ID_LO;
            5'h04: exp_reg = w ? 16'hffff : `PBMC_ADV_RST;
            5'h05: exp_reg = ro_status[0];
            5'h06: exp_reg = ro_status[1];
            5'h11: exp_reg = ro_status[2];
            5'h12: exp_reg = ro_status[3];
            5'h13: exp_reg = ro_status[4];
            5'h15: exp_reg = ro_status[5];
            5'h1b: exp_reg = ro_status[6];
            5'h07, 5'h10, 5'h14, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1c: exp_reg = {16{w}};
            default: exp_reg = 16'h0000;
        endcase
    endfunction : exp_reg

    initial begin
        #(80000 * 40);
        n_mismatch++;
        complete_run();
    end

    initial begin
        {sys_rst, tx_en, col_in, an_start, an_done, link_up, neg_spd, neg_dup} = 8'h8d;
        {loopback_pin, isolate_default_pin, station_address_pins} = 7'h00;
        foreach (ro_status[k]) ro_status[k] = 16'ha5a0 + 16'(k);
        repeat (5) @(posedge ref_clk);
        #3 sys_rst = 1'b0;
        repeat (20) @(posedge ref_clk);
        chk(outs, 16'h0033);
        for (int p = 0; p < 2; p++) begin
            link_up = (p == 0);
            if (p == 1)
                for (int a = 1; a < 32; a++) acc(WR, 5'(a), 16'hffff);
            for (int a = 1; a < 32; a++) begin
                acc(RD, 5'(a), 16'h0000);
                chk(rd, exp_reg(5'(a), p[0]));
            end
        end
        acc(WR, 5'h00, 16'h8000);
        chk(outs, 16'h0033);
        acc(RD, 5'h00, 16'h0000);
        chk(rd, 16'hb400);
        waitr();
        acc(RD, 5'h04, 16'h0000);
        chk(rd, `PBMC_ADV_RST);
        acc(RD, 5'h10, 16'h0000);
        chk(rd, 16'h0000);
        acc(WR, 5'h00, 16'h0100);
        chk(outs, 16'h0021);
        waitr();
        acc(WR, 5'h00, 16'h2000);
        chk(outs, 16'h0041);
        waitr();
        neg_spd = 1'b1;
        acc(WR, 5'h00, 16'h1000);
        chk(outs, 16'h0071);
        waitr();
        acc(WR, 5'h00, 16'h1a00);
        chk(outs, 16'h007c);
        an_start = 1'b1;
        @(posedge ref_clk);
        #3 an_start = 1'b0;
        acc(RD, 5'h00, 16'h0000);
        chk(rd, 16'h1800);
        acc(WR, 5'h00, 16'h1000);
        chk(outs, 16'h0070);
        acc(WR, 5'h1c, 16'h0001);
        acc(WR, 5'h00, 16'h1800);
        acc(RD, 5'h00, 16'h0000);
        chk(rd, 16'h1000);
        loopback_pin = 1'b1;
        acc(RD, 5'h00, 16'h0000);
        chk(rd, 16'h5000);
        chk(outs, 16'h00f0);
        loopback_pin = 1'b0;
        acc(RD, 5'h00, 16'h0000);
        chk(rd, 16'h1000);
        acc(WR, 5'h00, 16'h1080);
        tx_en = 1'b1;
        repeat (2) @(posedge ref_clk);
        #3 chk({14'h0, col_oe, col_out}, 16'h0003);
        tx_en = 1'b0;
        @(posedge ref_clk);
        #3 chk({15'h0, col_out}, 16'h0000);
        // Nonzero address: isolate follows the isolate strap after soft reset
        station_address_pins = 5'h05;
        acc(WR, 5'h00, 16'h8000);
        waitr();
        acc(RD, 5'h00, 16'h0000);
        chk(rd, 16'h3000);
        acc(RD, 5'h19, 16'h0000);
        chk(rd, 16'h0005);
        complete_run();
    end
endmodule : phy_basic_mode_control_regs_test
